// ### design/scpi_command_line_parser.sv
`timescale 1ns/1ps
`include "scpi_params.svh"
// Operation
// RL1 - keyword matches exact short or long form
// RL2 - common command header starts with asterisk
// RL3 - leading colon puts pointer at root
// RL4 - inner colon steps pointer down one level
// RL5 - semicolon keeps level for next command
// RL6 - colon after semicolon returns to root
// RL7 - commands act only after line terminator
// RL8 - terminator resets pointer to root
// RL9 - malformed line produces error report
// RL10 - power-up: root pointer, default parameters
// RL11 - reset command restores defaults, keeps pointer
// RL12 - common commands level-free; clear-status goes root
// RL13 - whitespace separates header and parameters only
// RL14 - commas split parameter list
// RL15 - setting commands have question-mark query form
// RL16 - events never queried; query-only needs mark
// RL17 - boolean takes ON/OFF/1/0, answers 1/0
// RL18 - missing character suffix becomes lowest value
// RL19 - numeric accepts MAX, MIN, DEF, queryable
// RL20 - keyword resolved on unique path from root
// RL21 - out-of-range value ignored, error queued
// RL22 - one character per cycle, stall during dispatch
module scpi_command_line_parser (
  input logic CLK,
  input logic RESET,
  input logic IN_VALID,
  input logic [7:0] IN_DATA,
  output logic IN_READY,
  output logic CMD_VALID,
  output scpi_pkg::cmd_t CMD,
  output logic RESP_VALID,
  output logic [15:0] RESP_DATA,
  output logic ERR_VALID,
  output logic [15:0] ERR_CODE,
  output logic TRIGGER,
  output logic MARK_STATE,
  output logic [3:0] SYNC_SEL,
  output logic [15:0] FREQ_VALUE,
  output logic [2:0] TREE_LEVEL
);
  import scpi_pkg::*;

  // ==========================================
  // vocabulary and command tree tables
  localparam logic [95:0] KW_TEXT [16] = '{"MARKER", "SYNC", "STATE", "SYSTEM", "ERROR",
    "FREQUENCY", "AOFF", "ON", "OFF", "MAXIMUM", "MINIMUM", "DEFAULT", "LINE", "RST", "CLS", "TRG"};
  localparam int KW_LONG [16] = '{6, 4, 5, 6, 5, 9, 4, 2, 3, 7, 7, 7, 4, 3, 3, 3};
  localparam int KW_SHORT [16] = '{4, 4, 4, 4, 3, 4, 4, 2, 3, 3, 3, 3, 4, 3, 3, 3};
  localparam logic [2:0] NODE_PARENT [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4, 3'h0, 3'h1};
  localparam node_kind_t NODE_KIND [8] = '{NK_BRANCH, NK_BOOL, NK_DISC, NK_BOOL,
    NK_BRANCH, NK_QONLY, NK_NUM, NK_EVENT};

  // ==========================================
  // state
  phase_t phase;
  logic [2:0] level;
  logic [2:0] cmd_node;
  common_t cmd_common;
  logic query;
  logic common;
  logic at_start;
  logic closed;
  logic nparam;
  logic [15:0] pval;
  logic pbad;
  logic pspec;
  logic [95:0] tok;
  logic [3:0] tok_len;
  logic [15:0] num;
  logic has_num;
  cmd_t queue [4];
  logic [2:0] q_count;
  logic [1:0] q_ptr;
  logic [15:0] last_err;

  // ==========================================
  // decode signals
  char_class_t cc;
  logic [15:0] hit;
  logic take;
  logic hdr_hit;
  logic [2:0] hdr_node;
  common_t hdr_common;
  logic pend;
  logic pv_ok;
  logic pv_spec;
  logic pv_bad;
  logic [15:0] pv_val;
  cmd_t entry;
  logic fin_ok;
  logic fin_empty;
  logic err;
  logic finish;
  logic clr_tok;
  logic append;
  logic add_digit;
  logic to_param;
  logic colon_root;
  logic colon_down;
  logic set_common;
  logic latch_param;
  logic close_tok;
  logic push;
  logic bad_line;
  logic good_line;
  logic disp;
  logic last;
  cmd_t cur;
  logic [19:0] next_num;
  logic [15:0] resp;

  char_class u_class (
    .ch(IN_DATA),
    .cls(cc)
  );

  // keyword comparators, one per vocabulary word
  for (genvar g = 0; g < `KW_COUNT; g++) begin : g_kw
    kw_match #(.TEXT(KW_TEXT[g]), .LONG_LEN(KW_LONG[g]), .SHORT_LEN(KW_SHORT[g])) u_kw (
      .tok(tok),
      .len(tok_len),
      .hit(hit[g])
    );
  end

  // input stalls while commands are dispatched
  assign IN_READY = (phase != PH_DISPATCH); // RL22
  assign take = IN_VALID && IN_READY; // RL22
  assign disp = (phase == PH_DISPATCH);
  assign cur = queue[q_ptr];
  assign last = (3'({1'b0, q_ptr}) + 3'h1) == q_count;
  assign pend = (tok_len != 4'h0) || has_num;
  assign next_num = 20'(num) * 20'h0000a + 20'(IN_DATA - 8'h30);
  assign TREE_LEVEL = level;

  // ==========================================
  // header resolution against current level
  always_comb begin
    hdr_hit = 1'b0;
    hdr_node = `NODE_ROOT;
    hdr_common = CC_NONE;
    if (common) begin
      if (hit[`KW_RST]) begin
        hdr_hit = 1'b1;
        hdr_common = CC_RST;
      end else if (hit[`KW_CLS]) begin
        hdr_hit = 1'b1;
        hdr_common = CC_CLS;
      end else if (hit[`KW_TRG]) begin
        hdr_hit = 1'b1;
        hdr_common = CC_TRG;
      end
    end else begin
      for (int k = 0; k < 7; k++) begin
        if (hit[k] && (NODE_PARENT[k+1] == level)) begin // RL20
          hdr_hit = 1'b1;
          hdr_node = 3'(k + 1);
        end
      end
    end
  end

  // ==========================================
  // parameter token evaluation
  always_comb begin
    pv_ok = 1'b0;
    pv_spec = 1'b0;
    pv_bad = 1'b0;
    pv_val = 16'h0000;
    case (NODE_KIND[cmd_node])
      NK_BOOL: begin
        if (hit[`KW_ON] || hit[`KW_OFF]) begin // RL17
          pv_ok = 1'b1;
          pv_val = {15'h0000, hit[`KW_ON]};
        end else if ((tok_len == 4'h0) && has_num && (num <= 16'h0001)) begin // RL17
          pv_ok = 1'b1;
          pv_val = num;
        end
      end
      NK_DISC: begin
        if (hit[`KW_LINE]) begin
          pv_ok = 1'b1;
          pv_val = num; // RL18
          pv_bad = num > `SYNC_MAX;
        end
      end
      NK_NUM: begin
        if (hit[`KW_MAX] || hit[`KW_MIN] || hit[`KW_DEF]) begin // RL19
          pv_ok = 1'b1;
          pv_spec = 1'b1;
          pv_val = hit[`KW_MAX] ? `FREQ_MAX : (hit[`KW_MIN] ? `FREQ_MIN : `DEF_FREQ);
        end else if ((tok_len == 4'h0) && has_num) begin
          pv_ok = 1'b1;
          pv_val = num;
          pv_bad = (num < `FREQ_MIN) || (num > `FREQ_MAX); // RL21
        end
      end
      default: ;
    endcase
  end

  // ==========================================
  // command built at ';' or end of line, with form checks
  always_comb begin
    entry = '0;
    fin_ok = 1'b0;
    fin_empty = 1'b0;
    if (phase == PH_HEADER) begin
      if (tok_len == 4'h0) begin
        fin_empty = at_start && !common;
      end else begin
        fin_ok = hdr_hit;
        entry.node = hdr_node;
        entry.common = hdr_common;
      end
    end else begin
      entry.node = cmd_node;
      entry.common = cmd_common;
      entry.query = query;
      entry.has_param = pend || nparam;
      entry.value = pend ? pv_val : pval;
      entry.bad_range = pend ? pv_bad : pbad;
      fin_ok = pend ? (pv_ok && !nparam) : 1'b1; // RL14
    end
    if (entry.common != CC_NONE) begin
      fin_ok = fin_ok && !entry.query && !entry.has_param;
    end else begin
      case (NODE_KIND[entry.node])
        NK_BRANCH: fin_ok = 1'b0;
        NK_EVENT: fin_ok = fin_ok && !entry.query && !entry.has_param; // RL16
        NK_QONLY: fin_ok = fin_ok && entry.query && !entry.has_param; // RL16
        default: fin_ok = fin_ok && (entry.query ? (!entry.has_param || pspec || pv_spec) : entry.has_param); // RL15
      endcase
    end
  end

  // ==========================================
  // per-character decision
  always_comb begin
    err = 1'b0;
    finish = 1'b0;
    clr_tok = 1'b0;
    append = 1'b0;
    add_digit = 1'b0;
    to_param = 1'b0;
    colon_root = 1'b0;
    colon_down = 1'b0;
    set_common = 1'b0;
    latch_param = 1'b0;
    close_tok = 1'b0;
    if (take && (phase == PH_HEADER)) begin
      clr_tok = 1'b1;
      if (cc.term || cc.semi) begin
        finish = 1'b1;
        err = !fin_ok && !fin_empty;
      end else if (cc.space || cc.quest) begin
        to_param = cc.quest || (tok_len != 4'h0); // RL13
        err = to_param && !hdr_hit;
        clr_tok = to_param;
      end else if (cc.colon) begin
        colon_root = (tok_len == 4'h0) && at_start && !common; // RL3 RL6
        colon_down = (tok_len != 4'h0) && hdr_hit && !common; // RL4
        err = !colon_root && !colon_down;
      end else if (cc.star) begin
        set_common = at_start && !common; // RL2
        err = !set_common;
        clr_tok = 1'b0;
      end else begin
        append = cc.letter && (tok_len != `TOK_MAX);
        err = !append;
        clr_tok = 1'b0;
      end
    end else if (take && (phase == PH_PARAM)) begin
      if (cc.term || cc.semi) begin
        finish = 1'b1;
        err = !fin_ok;
        clr_tok = 1'b1;
      end else if (cc.space) begin
        close_tok = pend; // RL13
      end else if (cc.comma) begin
        latch_param = pend && pv_ok && !nparam; // RL14
        err = !latch_param;
        clr_tok = 1'b1;
      end else if (cc.letter) begin
        append = !closed && !has_num && (tok_len != `TOK_MAX);
        err = !append;
      end else if (cc.digit) begin
        add_digit = !closed;
        err = closed;
      end else begin
        err = 1'b1;
      end
    end
    if (finish && fin_ok && (q_count == `QUEUE_DEPTH)) begin
      err = 1'b1;
    end
  end

  assign push = finish && fin_ok && !err;
  assign bad_line = take && cc.term && ((phase == PH_SKIP) || err); // RL9
  assign good_line = take && cc.term && !bad_line;

  // ==========================================
  // token accumulation
  always_ff @(posedge CLK) begin
    if (RESET || (take && (clr_tok || err || cc.term))) begin
      tok <= '0;
      tok_len <= 4'h0;
      num <= 16'h0000;
      has_num <= 1'b0;
    end else begin
      if (append) begin
        tok <= {tok[87:0], cc.upper};
        tok_len <= tok_len + 4'h1;
      end
      if (add_digit) begin
        num <= (next_num > 20'h0ffff) ? 16'hffff : next_num[15:0];
        has_num <= 1'b1;
      end
    end
  end

  // ==========================================
  // line control and tree pointer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      phase <= PH_HEADER;
      level <= `NODE_ROOT; // RL10
      cmd_node <= `NODE_ROOT;
      cmd_common <= CC_NONE;
      query <= 1'b0;
      common <= 1'b0;
      at_start <= 1'b1;
      closed <= 1'b0;
      nparam <= 1'b0;
      pval <= 16'h0000;
      pbad <= 1'b0;
      pspec <= 1'b0;
    end else if (disp) begin
      if (last) begin
        phase <= PH_HEADER;
      end
    end else if (take) begin
      if (cc.term || cc.semi) begin
        at_start <= 1'b1;
        query <= 1'b0;
        common <= 1'b0;
        closed <= 1'b0;
        nparam <= 1'b0;
        cmd_common <= CC_NONE;
      end
      if (cc.term) begin
        level <= `NODE_ROOT; // RL8
        phase <= (good_line && ((q_count != 3'h0) || push)) ? PH_DISPATCH : PH_HEADER; // RL7
      end else if (err || (phase == PH_SKIP)) begin
        phase <= PH_SKIP; // RL9
      end else begin
        if (!cc.space) begin
          at_start <= cc.semi; // RL5
        end
        if (cc.semi) begin
          phase <= PH_HEADER;
          if (entry.common == CC_CLS) begin
            level <= `NODE_ROOT; // RL12
          end
        end
        if (colon_root) begin
          level <= `NODE_ROOT; // RL3 RL6
        end
        if (colon_down) begin
          level <= hdr_node; // RL4
        end
        if (set_common) begin
          common <= 1'b1; // RL2
        end
        if (to_param) begin
          phase <= PH_PARAM;
          cmd_node <= hdr_node;
          cmd_common <= hdr_common;
          query <= cc.quest; // RL15
        end
        if (latch_param) begin
          nparam <= 1'b1;
          pval <= pv_val;
          pbad <= pv_bad;
          pspec <= pv_spec;
        end
        closed <= close_tok || (closed && !latch_param);
      end
    end
  end

  // ==========================================
  // command queue held until the terminator; data words need no reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      q_count <= 3'h0;
      q_ptr <= 2'h0;
    end else if (disp) begin
      q_ptr <= q_ptr + 2'h1;
      if (last) begin
        q_count <= 3'h0;
        q_ptr <= 2'h0;
      end
    end else if (bad_line) begin
      q_count <= 3'h0; // RL7
    end else if (push) begin
      queue[q_count[1:0]] <= entry;
      q_count <= q_count + 3'h1;
    end
  end

  // ==========================================
  // subsystem settings
  always_ff @(posedge CLK) begin
    if (RESET || (disp && (cur.common == CC_RST))) begin
      MARK_STATE <= `DEF_MARK_STATE; // RL10 RL11
      SYNC_SEL <= `DEF_SYNC_SEL;
      FREQ_VALUE <= `DEF_FREQ;
    end else if (disp && !cur.query && !cur.bad_range && (cur.common == CC_NONE)) begin // RL21
      case (cur.node)
        `NODE_MARK, `NODE_STATE: MARK_STATE <= cur.value[0];
        `NODE_SYNC: SYNC_SEL <= cur.value[3:0];
        `NODE_FREQ: FREQ_VALUE <= cur.value;
        default: ;
      endcase
    end
  end

  // query answer
  always_comb begin
    case (NODE_KIND[cur.node])
      NK_BOOL: resp = {8'h00, MARK_STATE ? `ASCII_ONE : `ASCII_ZERO}; // RL17
      NK_DISC: resp = {12'h000, SYNC_SEL};
      NK_NUM: resp = cur.has_param ? cur.value : FREQ_VALUE; // RL19
      NK_QONLY: resp = last_err;
      default: resp = 16'h0000;
    endcase
  end

  // ==========================================
  // dispatch outputs
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CMD_VALID <= 1'b0;
      CMD <= '0;
      RESP_VALID <= 1'b0;
      RESP_DATA <= 16'h0000;
      TRIGGER <= 1'b0;
    end else begin
      CMD_VALID <= disp && !cur.bad_range;
      TRIGGER <= disp && (cur.common == CC_TRG);
      RESP_VALID <= disp && cur.query; // RL15
      if (disp) begin
        CMD <= cur;
        RESP_DATA <= resp;
      end
    end
  end

  // ==========================================
  // error report and stored error for the error query
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ERR_VALID <= 1'b0;
      ERR_CODE <= `ERR_NONE;
      last_err <= `ERR_NONE;
    end else begin
      ERR_VALID <= bad_line || (disp && cur.bad_range);
      if (bad_line) begin
        ERR_CODE <= `ERR_CMD; // RL9
        last_err <= `ERR_CMD;
      end else if (disp && cur.bad_range) begin
        ERR_CODE <= `ERR_RANGE; // RL21
        last_err <= `ERR_RANGE;
      end else if (disp && ((cur.common == CC_CLS) || (cur.query && (cur.node == `NODE_ERR)))) begin
        last_err <= `ERR_NONE;
      end
    end
  end
endmodule

// ### design/scpi_params.svh
`ifndef SCPI_PARAMS_SVH
`define SCPI_PARAMS_SVH
// ==========================================
// token and queue sizes
`define TOK_MAX 4'hc
`define TOK_BITS 96
`define KW_COUNT 16
`define QUEUE_DEPTH 3'h4
// ==========================================
// tree nodes
`define NODE_ROOT 3'h0
`define NODE_MARK 3'h1
`define NODE_SYNC 3'h2
`define NODE_STATE 3'h3
`define NODE_SYST 3'h4
`define NODE_ERR 3'h5
`define NODE_FREQ 3'h6
`define NODE_AOFF 3'h7
// ==========================================
// keyword table positions of parameter words and common headers
`define KW_ON 7
`define KW_OFF 8
`define KW_MAX 9
`define KW_MIN 10
`define KW_DEF 11
`define KW_LINE 12
`define KW_RST 13
`define KW_CLS 14
`define KW_TRG 15
// ==========================================
// defaults and limits
`define DEF_MARK_STATE 1'b0
`define DEF_SYNC_SEL 4'h0
`define SYNC_MAX 16'h0003
`define DEF_FREQ 16'h03e8
`define FREQ_MIN 16'h0001
`define FREQ_MAX 16'h2710
// ==========================================
// error codes and boolean answer characters
`define ERR_NONE 16'h0000
`define ERR_CMD 16'hff9c
`define ERR_RANGE 16'hff22
`define ASCII_ONE 8'h31
`define ASCII_ZERO 8'h30
// ==========================================
// punctuation characters
`define CH_LF 8'h0a
`define CH_TAB 8'h09
`define CH_SPACE 8'h20
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_COMMA 8'h2c
`define CH_QUEST 8'h3f
`define CH_STAR 8'h2a
`endif

// ### design/scpi_pkg.sv
package scpi_pkg;
  // ==========================================
  // node kinds of the command tree
  typedef enum logic [2:0] {NK_BRANCH, NK_BOOL, NK_DISC, NK_NUM, NK_EVENT, NK_QONLY} node_kind_t;
  typedef enum logic [1:0] {CC_NONE, CC_RST, CC_CLS, CC_TRG} common_t;
  typedef enum logic [1:0] {PH_HEADER, PH_PARAM, PH_SKIP, PH_DISPATCH} phase_t;
  // ==========================================
  // one decoded command
  typedef struct packed {
    logic [2:0] node;
    common_t common;
    logic query;
    logic has_param;
    logic bad_range;
    logic [15:0] value;
  } cmd_t;
  // ==========================================
  // classified input character
  typedef struct packed {
    logic [7:0] upper;
    logic letter;
    logic digit;
    logic space;
    logic term;
    logic colon;
    logic semi;
    logic comma;
    logic quest;
    logic star;
  } char_class_t;
endpackage

// ### design/char_class.sv
`timescale 1ns/1ps
`include "scpi_params.svh"
module char_class (
  input logic [7:0] ch,
  output scpi_pkg::char_class_t cls
);
  import scpi_pkg::*;
  logic lower;
  // ==========================================
  // classification and case folding
  always_comb begin
    lower = (ch >= 8'h61) && (ch <= 8'h7a);
    cls.upper = lower ? (ch - 8'h20) : ch; // RL1
    cls.letter = lower || ((ch >= 8'h41) && (ch <= 8'h5a));
    cls.digit = (ch >= 8'h30) && (ch <= 8'h39);
    cls.space = (ch == `CH_SPACE) || (ch == `CH_TAB);
    cls.term = (ch == `CH_LF);
    cls.colon = (ch == `CH_COLON);
    cls.semi = (ch == `CH_SEMI);
    cls.comma = (ch == `CH_COMMA);
    cls.quest = (ch == `CH_QUEST);
    cls.star = (ch == `CH_STAR);
  end
endmodule

// ### design/kw_match.sv
`timescale 1ns/1ps
`include "scpi_params.svh"
module kw_match #(
  parameter logic [95:0] TEXT = '0,
  parameter int LONG_LEN = 1,
  parameter int SHORT_LEN = 1
) (
  input logic [95:0] tok,
  input logic [3:0] len,
  output logic hit
);
  // ==========================================
  // exact short or exact long form, letters already upper case
  always_comb begin
    hit = (len == 4'(LONG_LEN)) || (len == 4'(SHORT_LEN)); // RL1
    for (int i = 0; i < 12; i++) begin
      if ((i < int'(len)) && (i < LONG_LEN)) begin
        if (tok[8*(int'(len)-1-i) +: 8] != TEXT[8*(LONG_LEN-1-i) +: 8]) begin
          hit = 1'b0;
        end
      end
    end
  end
endmodule

// ### tb/text_source.sv
`timescale 1ns/1ps
// ==========
// remote controller: sends a text line, one char per handshake
module text_source (
  input logic CLK,
  input logic IN_READY,
  output logic IN_VALID,
  output logic [7:0] IN_DATA
);
  initial begin
    IN_VALID = 1'b0;
    IN_DATA = 8'h00;
  end
  // hold each char until the parser takes it; idle data is junk
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge CLK);
      IN_VALID = 1'b1;
      IN_DATA = s[i];
      while (IN_READY !== 1'b1) @(negedge CLK);
    end
    @(negedge CLK);
    IN_VALID = 1'b0;
    IN_DATA = ~IN_DATA;
  endtask
endmodule

// ### tb/scpi_parser_chk.sv
`timescale 1ns/1ps
// ==========
// port checks of the command parser
module scpi_parser_chk (
  input logic CLK,
  input logic RESET,
  input logic IN_VALID,
  input logic [7:0] IN_DATA,
  input logic IN_READY,
  input logic CMD_VALID,
  input scpi_pkg::cmd_t CMD,
  input logic RESP_VALID,
  input logic [15:0] RESP_DATA,
  input logic ERR_VALID,
  input logic [15:0] ERR_CODE,
  input logic TRIGGER,
  input logic MARK_STATE,
  input logic [3:0] SYNC_SEL,
  input logic [15:0] FREQ_VALUE,
  input logic [2:0] TREE_LEVEL
);
  import scpi_pkg::*;
  logic lf_take;
  // terminator accepted this cycle
  assign lf_take = IN_VALID && IN_READY && IN_DATA == 8'h0a;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========
  // assertions
  ready_fall_a: assert property ($fell(IN_READY) |-> $past(lf_take))
    else $error("stall without terminator");
  stall_len_a: assert property (!IN_READY |-> ##[1:4] IN_READY)
    else $error("stall too long");
  act_stall_a: assert property ((CMD_VALID || RESP_VALID || TRIGGER) |-> $past(IN_READY) == 1'b0)
    else $error("action outside dispatch");
  set_hold_a: assert property (!$stable({MARK_STATE, SYNC_SEL, FREQ_VALUE}) && !$past(RESET) |-> !$past(IN_READY))
    else $error("setting moved outside dispatch");
  lf_root_a: assert property (lf_take |=> TREE_LEVEL == 3'h0)
    else $error("pointer not root after terminator");
  trg_cause_a: assert property (TRIGGER |-> CMD.common == CC_TRG)
    else $error("trigger without trigger command");
  range_drop_a: assert property (ERR_VALID && ERR_CODE == 16'hff22 |-> !CMD_VALID && $stable(FREQ_VALUE))
    else $error("out of range value acted on");
  line_err_a: assert property (ERR_VALID && ERR_CODE == 16'hff9c |-> !CMD_VALID && !RESP_VALID && !TRIGGER)
    else $error("bad line dispatched");
  freq_lim_a: assert property (FREQ_VALUE >= 16'h0001 && FREQ_VALUE <= 16'h2710)
    else $error("frequency out of range");
  sync_lim_a: assert property (SYNC_SEL <= 4'h3)
    else $error("sync select out of range");
endmodule
bind scpi_command_line_parser scpi_parser_chk u_chk (.CLK(CLK), .RESET(RESET), .IN_VALID(IN_VALID),
  .IN_DATA(IN_DATA), .IN_READY(IN_READY), .CMD_VALID(CMD_VALID), .CMD(CMD), .RESP_VALID(RESP_VALID),
  .RESP_DATA(RESP_DATA), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE), .TRIGGER(TRIGGER),
  .MARK_STATE(MARK_STATE), .SYNC_SEL(SYNC_SEL), .FREQ_VALUE(FREQ_VALUE), .TREE_LEVEL(TREE_LEVEL));

// ### tb/test_scpi_command_line_parser.sv
`timescale 1ns/1ps
// ==========
// bench for the command line parser
module test_scpi_command_line_parser;
  import scpi_pkg::*;
  logic CLK, RESET, IN_VALID, IN_READY, CMD_VALID, RESP_VALID, ERR_VALID, TRIGGER, MARK_STATE;
  logic [7:0] IN_DATA;
  cmd_t CMD;
  logic [15:0] RESP_DATA, ERR_CODE, FREQ_VALUE, last_resp, last_err;
  logic [3:0] SYNC_SEL;
  logic [2:0] TREE_LEVEL;
  int err_total, total_checks, cycles, n_cmd, n_resp, n_err, n_trg, n_stall, line_no, seen_line;
  scpi_command_line_parser dut (.CLK(CLK), .RESET(RESET), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .CMD_VALID(CMD_VALID), .CMD(CMD), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA),
    .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE), .TRIGGER(TRIGGER), .MARK_STATE(MARK_STATE),
    .SYNC_SEL(SYNC_SEL), .FREQ_VALUE(FREQ_VALUE), .TREE_LEVEL(TREE_LEVEL));
  text_source src (.CLK(CLK), .IN_READY(IN_READY), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA));
  // clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // ==========
  // monitor and timeout
  always @(negedge CLK) begin
    cycles++;
    // a new line from run clears the per-line counts
    if (line_no != seen_line) begin
      seen_line = line_no;
      n_cmd = 0;
      n_resp = 0;
      n_err = 0;
      n_trg = 0;
      n_stall = 0;
    end
    if (IN_READY !== 1'b1) n_stall++;
    if (CMD_VALID === 1'b1) n_cmd++;
    if (TRIGGER === 1'b1) n_trg++;
    if (RESP_VALID === 1'b1) begin
      n_resp++;
      last_resp = RESP_DATA;
    end
    if (ERR_VALID === 1'b1) begin
      n_err++;
      last_err = ERR_CODE;
    end
  end
  // ==========
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one line, let dispatch finish, pointer back at root
  task automatic run(input string s);
    line_no++;
    src.send(s);
    repeat (8) @(negedge CLK);
    chk(16'(TREE_LEVEL), 16'h0);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    chk({15'h0, IN_READY, 16'(MARK_STATE)} >> 16, 16'h1);
    chk(16'(MARK_STATE), 16'h0);
    chk(16'(SYNC_SEL), 16'h0);
    chk(FREQ_VALUE, 16'h03e8);
    chk(16'(TREE_LEVEL), 16'h0);
  endtask
  task automatic t_keyword();
    src.send(":mark:stat\ton");
    chk(16'(MARK_STATE), 16'h0);
    run("\n");
    chk(16'(MARK_STATE), 16'h1);
    run("MARKER:STATE OFF\n");
    chk(16'(MARK_STATE), 16'h0);
    run(":MARKE ON\n");
    chk(last_err, 16'hff9c);
    chk(16'(n_cmd), 16'h0);
    run(":MA RK ON\n");
    chk(16'(n_err), 16'h1);
  endtask
  task automatic t_bool();
    run(":MARK 1\n");
    chk(16'(MARK_STATE), 16'h1);
    run(":MARK?\n");
    chk(last_resp, 16'h0031);
    run(":MARK:STAT 0;:MARK:STAT?\n");
    chk(last_resp, 16'h0030);
    chk(16'(n_resp), 16'h1);
  endtask
  task automatic t_tree();
    run(":MARK:SYNC LINE2;STAT ON\n");
    chk(16'(SYNC_SEL), 16'h2);
    chk(16'(MARK_STATE), 16'h1);
    run("MARK:SYNC LINE3;:FREQ 500\n");
    chk(FREQ_VALUE, 16'h01f4);
    chk(16'(SYNC_SEL), 16'h3);
    run(":MARK:SYNC?\n");
    chk(last_resp, 16'h0003);
    run(":MARK:SYNC LINE1;FREQ 7\n");
    chk(16'(SYNC_SEL), 16'h3);
    run(":SYNC LINE1\n");
    chk(16'(n_err), 16'h1);
    run(":MARK:FREQ 7\n");
    chk(16'(n_err), 16'h1);
    run(":MARK:SYNC LINE\n");
    chk(16'(SYNC_SEL), 16'h0);
  endtask
  task automatic t_num();
    run(":FREQ MAX\n");
    chk(FREQ_VALUE, 16'h2710);
    chk(CMD.value, 16'h2710);
    run(":FREQ? MIN\n");
    chk(last_resp, 16'h0001);
    run(":FREQ DEF\n");
    chk(FREQ_VALUE, 16'h03e8);
    run(":FREQ 10001;:FREQ 1\n");
    chk(last_err, 16'hff22);
    chk(FREQ_VALUE, 16'h0001);
    run(":SYST:ERR?\n");
    chk(last_resp, 16'hff22);
    run(":FREQ 20,30\n");
    chk(last_err, 16'hff9c);
  endtask
  task automatic t_common();
    run(":MARK:AOFF?\n");
    chk(16'(n_err), 16'h1);
    run(":SYST:ERR\n");
    chk(16'(n_err), 16'h1);
    run(":MARK:AOFF\n");
    chk(16'(n_cmd), 16'h1);
    run("TRG\n");
    chk(16'(n_trg), 16'h0);
    run(":MARK:SYNC LINE2;*TRG;STAT OFF\n");
    chk(16'(n_trg), 16'h1);
    chk(16'(MARK_STATE), 16'h0);
    run(":MARK:SYNC LINE3;*CLS;STAT ON\n");
    chk(16'(MARK_STATE), 16'h0);
    run(":FREQ 77;:MARK:SYNC LINE1;*RST;STAT ON\n");
    chk(FREQ_VALUE, 16'h03e8);
    chk(16'(SYNC_SEL), 16'h0);
    chk(16'(MARK_STATE), 16'h1);
  endtask
  task automatic t_queue();
    run(":MARK 1;:MARK 0;:FREQ 5;:FREQ 6\n");
    chk(16'(n_stall), 16'h4);
    chk(16'(n_cmd), 16'h4);
    run(":FREQ 1;:FREQ 2;:FREQ 3;:FREQ 4;:FREQ 9\n");
    chk(FREQ_VALUE, 16'h0006);
  endtask
  // ==========
  // main sequence
  initial begin
    RESET = 1'b1;
    repeat (12) @(negedge CLK);
    RESET = 1'b0;
    // scenarios race a cycle ceiling; a hang counts as a mismatch
    fork
      begin
        t_reset();
        t_keyword();
        t_bool();
        t_tree();
        t_num();
        t_common();
        t_queue();
      end
      begin
        wait (cycles == 5000);
        chk(16'(cycles), 16'h0000);
      end
    join_any
    test_done();
  end
endmodule
